//--- src/asc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// byte offsets inside the 4 KiB register window
`define ASC_OFF_SC 12'h038
`define ASC_OFF_RES 12'h03c
`define ASC_OFF_CLK 12'h040

// status and control register fields
`define ASC_SC_FLAG 7
`define ASC_SC_IEN 6
`define ASC_SC_CONT 5
`define ASC_CH_HI 4
`define ASC_CH_POWER_OFF 5'h1f

// clock register fields
`define ASC_CK_SRC 4
`define ASC_DIV_HI 2
`define ASC_DIV_RST 3'h0

// conversion timing in divided converter clock periods
`define ASC_SAMPLE_TICKS 4'h8
`define ASC_LAST_TICK 4'hf
`define ASC_DIV_MAX_M1 4'hf

// bus answers
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2

`endif

//--- src/asc_pkg.sv
// shared types of the converter control block
package asc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SAMPLE = 3'h2,
		ST_CONVERT = 3'h4
	} asc_state_type;
endpackage

//--- src/asc_clkdiv.sv
// converter clock source select and prescaler, giving a tick enable
`include "asc_defines.svh"
module asc_clkdiv
	import asc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// settings
	input wire logic src_bus,
	input wire logic [2:0] div_code,
	input wire logic crystal_clk_en,
	// output enable pulse
	output logic adc_tick
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic in_tick;
	logic [3:0] limit;

	// top bit set means divide by sixteen whatever the low bits say
	function automatic logic [3:0] div_limit(input logic [2:0] code);
		div_limit = code[2] ? `ASC_DIV_MAX_M1 :
			4'((5'h1 << code[1:0]) - 5'h1);
	endfunction

	// bus clock is aclk itself, the crystal arrives as an enable
	assign in_tick = src_bus | crystal_clk_en;
	assign limit = div_limit(div_code);
	assign adc_tick = in_tick && (cnt_q >= limit);
	assign cnt_d = adc_tick ? 4'h0 : cnt_q + 4'h1;

	// counts input ticks; a ratio change mid-conversion shifts timing
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_q <= 4'h0;
		else if (in_tick)
			cnt_q <= cnt_d;
	end
endmodule // asc_clkdiv

//--- src/asc_sar.sv
// successive approximation sequencer, eight settle ticks then eight bits
`include "asc_defines.svh"
module asc_sar
	import asc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic start,
	input wire logic abort,
	input wire logic adc_tick,
	// analog side
	input wire logic comparator_high,
	output logic [7:0] dac_code,
	output logic sampling,
	// status
	output logic busy,
	output logic done,
	output logic [7:0] result
);
	asc_state_type state_q;
	asc_state_type state_d;
	logic [3:0] tick_q;
	logic [7:0] code_q;
	logic [7:0] trial_bit;
	logic [7:0] trial;
	logic synced_q;
	logic step;

	// bit under test during tick 8..15, msb first
	assign trial_bit = 8'h80 >> tick_q[2:0];
	assign trial = code_q | trial_bit;
	assign dac_code = (state_q == ST_CONVERT) ? trial : 8'h00;
	assign sampling = (state_q == ST_SAMPLE);
	assign busy = (state_q != ST_IDLE);
	// the divider runs free, so the first tick after start only lines up
	// with it; skipping that tick keeps a conversion at 16 to 17 periods
	assign step = busy && adc_tick && synced_q;
	// comparator high means input at or above trial level
	assign done = (state_q == ST_CONVERT) && step &&
		(tick_q == `ASC_LAST_TICK) && !abort;
	assign result = comparator_high ? trial : code_q;

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start)
					state_d = ST_SAMPLE;
			end
			ST_SAMPLE: begin
				if (step && tick_q == `ASC_SAMPLE_TICKS - 4'h1)
					state_d = ST_CONVERT;
			end
			ST_CONVERT: begin
				if (done)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		if (abort)
			state_d = ST_IDLE;
	end

	// state, tick count and partial code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			synced_q <= 1'b0;
			tick_q <= 4'h0;
			code_q <= 8'h00;
		end else begin
			state_q <= state_d;
			if (start || abort) begin
				synced_q <= 1'b0;
				tick_q <= 4'h0;
				code_q <= 8'h00;
			end else if (step) begin
				tick_q <= tick_q + 4'h1;
				if (state_q == ST_CONVERT && comparator_high)
					code_q <= trial;
			end else if (busy && adc_tick)
				synced_q <= 1'b1;
		end
	end
endmodule // asc_sar

//--- src/asc_top.sv
// converter control: register slave, conversion sequencing, requests
// Summary of operation
// - code ff at or above high reference, 00 at ground, linear between
// - a status write with any channel code but all ones starts a conversion lasting 16 to 17 ticks
// - continuous mode overwrites the result each conversion, read or not
// - continuous mode runs conversions back to back until bit cleared
// - continuous mode flag stays set until status write or result read
// - interrupts off: flag read-only, set at end, cleared by write/read
// - interrupts on: request at every end, to processor when bit is 0
// - interrupts on: flag bit is writable target select, 1 means dma
// - request drops on result read or status write; reset clears enable
// - continuous bit 1 repeats, 0 gives one conversion; reset clears
// - five-bit channel field, codes 0 to 7 pick external inputs 0 to 7
// - all-ones channel code powers converter down; reset loads all ones
// - wait mode changes nothing; enabled request can wake processor
// - stop mode aborts any conversion; conversions resume after stop
// - eight-bit result register loads each time a conversion completes
// - divider codes 0 to 3 give 1,2,4,8; top bit set gives 16
// - clock source bit 1 picks bus clock, 0 crystal; reset crystal
//
// Design decision made here: the AXI4-Lite slave port.
`include "asc_defines.svh"
module asc_top
	import asc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clocking and power modes
	input wire logic crystal_clk_en,
	input wire logic wait_mode,
	input wire logic stop_mode,
	// analog comparator and input multiplexer
	input wire logic comparator_high,
	output logic [4:0] mux_channel,
	output logic [7:0] dac_code,
	output logic sampling,
	output logic analog_power_down,
	// service requests
	output logic cpu_irq,
	output logic dma_req
);
	logic [11:0] awaddr_q;
	logic aw_full_q;
	logic [7:0] wdata_q;
	logic wlane_q;
	logic w_full_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic flag_q;
	logic ien_q;
	logic cont_q;
	logic [4:0] chan_q;
	logic src_bus_q;
	logic [2:0] div_q;
	logic [7:0] result_q;
	logic irq_q;
	logic pending_q;
	logic wr_fire;
	logic wr_sc;
	logic wr_clk;
	logic wr_hit;
	logic ar_fire;
	logic [11:0] ar_off;
	logic rd_hit;
	logic rd_res;
	logic [7:0] rd_byte;
	logic pwr_off;
	logic adc_tick;
	logic busy;
	logic done;
	logic [7:0] sar_result;
	logic start;
	logic abort;
	logic new_ien;
	logic unused_ok;

	// prot and upper write lanes carry nothing for byte-wide registers
	assign unused_ok = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1],
		s_axi_awaddr[31:12], s_axi_araddr[31:12], s_axi_wdata[31:8],
		wait_mode};

	// address and data are held until both have arrived
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// write decode; only byte lane 0 carries register bits
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign wr_sc = wr_fire && wlane_q && awaddr_q == `ASC_OFF_SC;
	assign wr_clk = wr_fire && wlane_q && awaddr_q == `ASC_OFF_CLK;
	assign wr_hit = awaddr_q == `ASC_OFF_SC ||
		awaddr_q == `ASC_OFF_CLK || awaddr_q == `ASC_OFF_RES;
	assign new_ien = wdata_q[`ASC_SC_IEN];

	// read decode; reading the result has side effects on flag and request
	assign ar_fire = s_axi_arvalid && !rvalid_q;
	assign ar_off = s_axi_araddr[11:0];
	assign rd_res = ar_fire && ar_off == `ASC_OFF_RES;
	assign rd_hit = ar_off == `ASC_OFF_SC || ar_off == `ASC_OFF_RES ||
		ar_off == `ASC_OFF_CLK;
	assign rd_byte = (ar_off == `ASC_OFF_SC) ?
			{flag_q, ien_q, cont_q, chan_q} :
		(ar_off == `ASC_OFF_RES) ? result_q :
		(ar_off == `ASC_OFF_CLK) ? {3'h0, src_bus_q, 1'h0, div_q} : 8'h00;

	// axi channel holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= 12'h000;
			aw_full_q <= 1'b0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `ASC_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `ASC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				awaddr_q <= s_axi_awaddr[11:0];
				aw_full_q <= 1'b1;
			end else if (wr_fire)
				aw_full_q <= 1'b0;
			if (s_axi_wvalid && !w_full_q) begin
				wdata_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
				w_full_q <= 1'b1;
			end else if (wr_fire)
				w_full_q <= 1'b0;
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
			end else if (s_axi_bready)
				bvalid_q <= 1'b0;
			if (ar_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= {24'h000000, rd_byte};
				rresp_q <= rd_hit ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
			end else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	// control fields; all-ones channel powers down the analog part
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_q <= 1'b0;
			cont_q <= 1'b0;
			chan_q <= `ASC_CH_POWER_OFF;
			src_bus_q <= 1'b0;
			div_q <= `ASC_DIV_RST;
		end else begin
			if (wr_sc) begin
				ien_q <= new_ien;
				cont_q <= wdata_q[`ASC_SC_CONT];
				chan_q <= wdata_q[`ASC_CH_HI:0];
			end
			if (wr_clk) begin
				src_bus_q <= wdata_q[`ASC_CK_SRC];
				div_q <= wdata_q[`ASC_DIV_HI:0];
			end
		end
	end

	assign pwr_off = chan_q == `ASC_CH_POWER_OFF;
	assign mux_channel = chan_q;
	assign analog_power_down = pwr_off;

	// a status write abandons the running conversion; stop aborts it as well
	assign abort = busy && (wr_sc || stop_mode);
	assign start = pending_q && !busy && !stop_mode && !pwr_off && !wr_sc;

	// pending survives stop so conversions resume when it ends
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pending_q <= 1'b0;
		else if (wr_sc)
			pending_q <= wdata_q[`ASC_CH_HI:0] != `ASC_CH_POWER_OFF;
		else if (done && cont_q)
			pending_q <= 1'b1;
		else if (abort)
			pending_q <= 1'b1;
		else if (start || pwr_off)
			pending_q <= 1'b0;
	end

	// result loads whole in one edge, even if unread
	always_ff @(posedge aclk) begin
		if (!aresetn)
			result_q <= 8'h00;
		else if (done)
			result_q <= sar_result;
	end

	// flag: completion when interrupts off, target select when on;
	// a completion landing with a result read still sets it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			flag_q <= 1'b0;
		else if (wr_sc)
			flag_q <= new_ien ? wdata_q[`ASC_SC_FLAG] : 1'b0;
		else if (done && !ien_q)
			flag_q <= 1'b1;
		else if (rd_res && !ien_q)
			flag_q <= 1'b0;
	end

	// request level; wait mode leaves it running so it can wake the core
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_q <= 1'b0;
		else if (wr_sc)
			irq_q <= 1'b0;
		else if (done && ien_q)
			irq_q <= 1'b1;
		else if (rd_res || !ien_q)
			irq_q <= 1'b0;
	end

	assign cpu_irq = irq_q && !flag_q;
	assign dma_req = irq_q && flag_q;

	// converter tick from the selected source
	asc_clkdiv u_clkdiv (
		.aclk(aclk),
		.aresetn(aresetn),
		.src_bus(src_bus_q),
		.div_code(div_q),
		.crystal_clk_en(crystal_clk_en),
		.adc_tick(adc_tick)
	);

	// approximation sequencer
	asc_sar u_sar (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start),
		.abort(abort),
		.adc_tick(adc_tick),
		.comparator_high(comparator_high),
		.dac_code(dac_code),
		.sampling(sampling),
		.busy(busy),
		.done(done),
		.result(sar_result)
	);

	// helper: converter ticks since the start of the running conversion
	logic [4:0] tk_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || start)
			tk_q <= 5'h00;
		else if (busy && adc_tick)
			tk_q <= tk_q + 5'h01;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_conv_length: assert property (done |-> tk_q == 5'h10)
		else $error("conversion length in ticks is wrong");
	a_result_load: assert property (done |=> result_q == $past(sar_result))
		else $error("result not loaded at conversion end");
	a_cont_restart: assert property (done && cont_q && !wr_sc && !stop_mode
		&& !pwr_off ##1 !stop_mode && !wr_sc |=> busy)
		else $error("continuous mode did not restart");
	a_single_stop: assert property (done && !cont_q && !wr_sc |=> !busy [*2])
		else $error("single mode started another conversion");
	a_flag_set: assert property (done && !ien_q && !wr_sc |=> flag_q)
		else $error("flag not set at conversion end");
	a_irq_raise: assert property (done && ien_q && !wr_sc
		|=> (cpu_irq || dma_req) && cpu_irq == !flag_q)
		else $error("request missing or wrong target");
	a_irq_clear: assert property ((wr_sc || rd_res) && !done
		|=> !cpu_irq && !dma_req)
		else $error("request not withdrawn");
	a_stop_abort: assert property (stop_mode |=> !busy)
		else $error("conversion survived stop mode");
	a_write_restart: assert property (wr_sc && !stop_mode
		&& wdata_q[`ASC_CH_HI:0] != `ASC_CH_POWER_OFF ##1 !stop_mode |=> busy)
		else $error("status write did not restart conversion");
	a_power_off: assert property (pwr_off |-> !busy)
		else $error("converting while powered down");

	c_single_done: cover property (done && !cont_q);
	c_cont_twice: cover property (done && cont_q ##[1:400] done);
	c_dma_target: cover property (dma_req);
	c_stop_abort: cover property (busy && stop_mode);
endmodule // asc_top

//--- dv/asc_analog_model.sv
// behavioural input multiplexer and comparator facing the sequencer
module asc_analog_model
	import asc_pkg::*;
(
	// clock
	input wire logic aclk,
	// converter side
	input wire logic [4:0] mux_channel,
	input wire logic [7:0] dac_code,
	input wire logic analog_power_down,
	output logic comparator_high
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] level [8];
	logic [7:0] vin;
	logic last_q = 1'b0;

	// internal references sit at the rails; unused codes wander with the trial
	always_comb begin
		case (mux_channel)
			5'h1c, 5'h1d: vin = 8'hff;
			5'h1e: vin = 8'h00;
			default: vin = mux_channel[4:3] == 2'h0 ? level[mux_channel[2:0]] :
				dac_code ^ 8'h5a;
		endcase
	end

	// powered down the comparator output is garbage, so it toggles
	always @(posedge aclk) last_q <= comparator_high;
	assign comparator_high = analog_power_down ? !last_q : vin >= dac_code;
endmodule // asc_analog_model

//--- dv/asc_top_tb.sv
// self-checking bench for the converter control block
module asc_top_tb
	import asc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic crystal_clk_en = 1'h0, wait_mode = 1'h0, stop_mode = 1'h0;
	logic comparator_high, sampling, analog_power_down, cpu_irq, dma_req;
	logic [4:0] mux_channel, c;
	logic [7:0] dac_code, v;
	logic [2:0] code;
	logic [34:0] e;
	logic [34:0] exp_q [$];
	int error_cnt = 0, cmp_count = 0, seed = 23695, n, p;

	asc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .crystal_clk_en, .wait_mode, .stop_mode,
		.comparator_high, .mux_channel, .dac_code, .sampling,
		.analog_power_down, .cpu_irq, .dma_req);
	asc_analog_model amod (.aclk, .mux_channel, .dac_code,
		.analog_power_down, .comparator_high);

	initial forever #25 aclk = ~aclk;

	// crystal edges arrive irregularly, unrelated to bus traffic
	always @(posedge aclk) crystal_clk_en <= 1'($random(seed));

	task automatic chk(input string nm, input logic [33:0] got,
		input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {20'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin
				do @(posedge aclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'h0;
			end
			begin
				do @(posedge aclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'h0;
			end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask

	// read: the expectation is noted first, the monitor compares the answer
	task automatic rd(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] r = 2'h0);
		@(posedge aclk);
		exp_q.push_back({r == 2'h0, r, 24'h0, r == 2'h0 ? d : 8'h00});
		s_axi_araddr <= {20'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask

	// error answers carry no defined data, so only the code is compared
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = exp_q.pop_front();
			chk("rdata", {s_axi_rresp, e[34] ? s_axi_rdata : 32'h0}, e[33:0]);
		end
		// every write in this bench targets a mapped register
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", s_axi_bresp, 34'h0);
	end

	task automatic wait_req();
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(cpu_irq || dma_req));
	endtask

	function automatic logic [7:0] expv(input logic [4:0] ch);
		return ch[4] ? (ch == 5'h1e ? 8'h00 : 8'hff) : amod.level[ch[2:0]];
	endfunction

	// watchdog: the whole sequence needs well under 8000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		summarize();
	end

	initial begin
		for (int i = 0; i < 8; i++) amod.level[i] = 8'($random(seed));
		amod.level[0] = 8'hff;
		amod.level[7] = 8'h00;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		chk("pwr", {analog_power_down, mux_channel}, 34'h3f);
		rd(12'h038, 8'h1f);
		rd(12'h040, 8'h00);
		rd(12'h03c, 8'h00);
		rd(12'h100, 8'h00, 2'h2);
		wait_mode <= 1'h1;
		// first result after power-off is thrown away by a status write
		wr(12'h038, 8'h40);
		wait_req();
		for (int i = 0; i < 11; i++) begin
			c = i < 8 ? 5'(i) : 5'(i + 20);
			wr(12'h038, {3'h2, c});
			chk("clr", {dma_req, cpu_irq}, 34'h0);
			wait_req();
			chk("cpu", {dma_req, cpu_irq}, 34'h1);
			rd(12'h03c, expv(c));
			chk("drop", cpu_irq, 34'h0);
		end
		// clock settings only change while the converter is idle
		for (int d = 0; d < 5; d++) begin
			code = d == 4 ? 3'h7 : 3'(d);
			p = 1 << d;
			wr(12'h040, {5'h2, code});
			wr(12'h038, 8'hc3);
			wait_req();
			chk("time", 34'(n >= 16 * p - 2 && n <= 17 * p + 3), 34'h1);
			chk("dma", {dma_req, cpu_irq}, 34'h2);
			rd(12'h038, 8'hc3);
			rd(12'h03c, expv(5'h3));
			chk("dmadrop", dma_req, 34'h0);
		end
		// slowest clock: one conversion lasts at most 17 x 16 cycles
		wr(12'h038, 8'h85);
		repeat (150) @(posedge aclk);
		stop_mode <= 1'h1;
		repeat (300) @(posedge aclk);
		rd(12'h038, 8'h05);
		stop_mode <= 1'h0;
		repeat (300) @(posedge aclk);
		rd(12'h038, 8'h85);
		rd(12'h03c, expv(5'h5));
		rd(12'h038, 8'h05);
		wr(12'h038, 8'h05);
		repeat (150) @(posedge aclk);
		wr(12'h038, 8'h06);
		repeat (200) @(posedge aclk);
		rd(12'h038, 8'h06);
		repeat (100) @(posedge aclk);
		rd(12'h038, 8'h86);
		rd(12'h03c, expv(5'h6));
		// continuous: flag sticks, result follows the input
		wr(12'h038, 8'h24);
		repeat (300) @(posedge aclk);
		rd(12'h038, 8'ha4);
		repeat (300) @(posedge aclk);
		rd(12'h038, 8'ha4);
		rd(12'h03c, expv(5'h4));
		amod.level[4] <= ~amod.level[4];
		repeat (600) @(posedge aclk);
		rd(12'h03c, expv(5'h4));
		wr(12'h038, 8'h04);
		repeat (300) @(posedge aclk);
		v = expv(5'h4);
		amod.level[4] <= ~amod.level[4];
		repeat (300) @(posedge aclk);
		rd(12'h038, 8'h84);
		rd(12'h03c, v);
		// converter not needed to wake the processor: power it off
		wr(12'h038, 8'h1f);
		chk("off", {analog_power_down, mux_channel}, 34'h3f);
		summarize();
	end
endmodule // asc_top_tb
